// >>> rtl/ocl_osc_ctrl.sv
`timescale 1ns/1ps
// Contract
// - with fail monitor on, freeze bit 7 set locks source and switch requests
// - with fail monitor config 0, selections never locked by freeze bit
// - bit 6 is pin-map write guard, 1 active, 0 inactive
// - guard changes only after the unlock sequence; other writes leave it
// - single-session config 1 forbids clearing guard once set until reset
// - bit 5 reads 1 when PLL enabled and locked or start-up timer expired
// - bit 5 forced 0 during any switch or non-PLL mode
// - bit 4 always reads zero, writes ignored
// - bit 3 set when the fail monitor reports a clock failure
// - bit 2 keeps primary oscillator running in sleep when 1
// - bit 1 enables the 32 kHz secondary oscillator
// - writing 1 to bit 0 starts switch to next source; reads 0 when done
// - next source resets from the initial oscillator config bits
// - guard set blocks writes to pin input and output map registers
module ocl_osc_ctrl (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire ocl_pkg::ocl_cfg_type cfg_i,
    input  wire ocl_pkg::ocl_pll_type pll_i,
    input  wire logic                 clock_fail_detect_i,
    input  wire logic                 switch_done_i,
    input  wire logic                 sleep_i,
    output logic                      primary_osc_run_o,
    output logic                      secondary_osc_on_o,
    output logic                      switch_start_o,
    output logic      [2:0]           next_source_o,
    output logic                      pin_map_locked_o,
    output logic                      irq_o
);
    logic                   ack_q, ack_d;
    logic [31:0]            rdat_q, rdat_d;
    logic                   freeze_q, freeze_d;
    logic                   guard_q, guard_d;
    logic                   settled_q, settled_d;
    logic                   fail_q, fail_d;
    logic                   prim_q, prim_d;
    logic                   sec_q, sec_d;
    logic                   sw_q, sw_d;
    logic [2:0]             nsrc_q, nsrc_d;
    logic [2:0]             stat_q, stat_d;
    logic [2:0]             mask_q, mask_d;
    logic                   irq_q, irq_d;
    logic                   prim_run_q, prim_run_d;
    ocl_pkg::ocl_unlock_type unl_q, unl_d;

    logic       acc, wr, rd, wr_ctrl, wr_lo, wr_hi, locked, settled_raw;
    logic [7:0] lo;
    logic [15:0] ctrl_word;
    logic       key_write_chk;

    // bus strobes; access acts on the edge that raises ack
    assign acc     = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr      = acc && wb_we_i;
    assign rd      = acc && !wb_we_i;
    assign wr_ctrl = wr && (wb_adr_i == ocl_pkg::OSC_CTRL_ADDR);
    assign wr_lo   = wr_ctrl && wb_sel_i[0];
    assign wr_hi   = wr_ctrl && wb_sel_i[1];
    assign lo      = wb_dat_i[7:0];
    // freeze only counts while the fail monitor is configured on
    assign locked  = cfg_i.fail_monitor_cfg_bit && freeze_q;
    assign settled_raw = pll_i.pll_enabled && pll_i.pll_mode_selected
                         && (pll_i.pll_locked || pll_i.pll_timer_done)
                         && !sw_q && !switch_done_i;

    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[ocl_pkg::FREEZE_BIT]  = freeze_q;
        ctrl_word[ocl_pkg::GUARD_BIT]   = guard_q;
        ctrl_word[ocl_pkg::SETTLED_BIT] = settled_q;
        ctrl_word[ocl_pkg::UNUSED_BIT]  = 1'b0;
        ctrl_word[ocl_pkg::FAIL_BIT]    = fail_q;
        ctrl_word[ocl_pkg::PRIM_BIT]    = prim_q;
        ctrl_word[ocl_pkg::SEC_BIT]     = sec_q;
        ctrl_word[ocl_pkg::SWITCH_BIT]  = sw_q;
        ctrl_word[ocl_pkg::NEXT_SRC_LSB +: 3] = nsrc_q;
    end

    // bus slave
    always_comb
    begin
        ack_d  = acc;
        rdat_d = '0;
        if (rd)
        begin
            unique case (wb_adr_i)
                ocl_pkg::OSC_CTRL_ADDR: rdat_d = {16'h0000, ctrl_word};
                ocl_pkg::IRQ_STAT_ADDR: rdat_d = {29'h0, stat_q};
                ocl_pkg::IRQ_MASK_ADDR: rdat_d = {29'h0, mask_q};
                ocl_pkg::PLL_STAT_ADDR: rdat_d = {31'h0, settled_q};
                default:                rdat_d = '0;
            endcase
        end
    end

    // unlock sequence tracker; any other control write disarms it
    always_comb
    begin
        unl_d = unl_q;
        if (wr_ctrl)
        begin
            unique case (unl_q)
                ocl_pkg::UNL_IDLE:
                    unl_d = (wr_lo && lo == ocl_pkg::UNLOCK_KEY1) ? ocl_pkg::UNL_KEY1
                                                                : ocl_pkg::UNL_IDLE;
                ocl_pkg::UNL_KEY1:
                    unl_d = (wr_lo && lo == ocl_pkg::UNLOCK_KEY2) ? ocl_pkg::UNL_ARMED
                                                                : ocl_pkg::UNL_IDLE;
                ocl_pkg::UNL_ARMED:
                    unl_d = ocl_pkg::UNL_IDLE;
                default:
                    unl_d = ocl_pkg::UNL_IDLE;
            endcase
        end
    end

    // control fields
    always_comb
    begin
        logic key_write;
        key_write = 1'b0;
        freeze_d  = freeze_q;
        guard_d   = guard_q;
        prim_d    = prim_q;
        sec_d     = sec_q;
        sw_d      = sw_q;
        nsrc_d    = nsrc_q;
        fail_d    = fail_q;
        // key bytes outside the armed state only feed the sequence, they alter no field
        key_write = wr_lo && unl_q != ocl_pkg::UNL_ARMED
                    && (lo == ocl_pkg::UNLOCK_KEY1 || lo == ocl_pkg::UNLOCK_KEY2);
        if (wr_lo && !key_write)
        begin
            freeze_d = lo[ocl_pkg::FREEZE_BIT];
            prim_d   = lo[ocl_pkg::PRIM_BIT];
            sec_d    = lo[ocl_pkg::SEC_BIT];
            if (!lo[ocl_pkg::FAIL_BIT])
                fail_d = 1'b0;
            if (unl_q == ocl_pkg::UNL_ARMED)
            begin
                if (lo[ocl_pkg::GUARD_BIT] || !(cfg_i.single_session_map_cfg && guard_q))
                    guard_d = lo[ocl_pkg::GUARD_BIT];
            end
            if (lo[ocl_pkg::SWITCH_BIT] && !locked)
                sw_d = 1'b1;
        end
        if (wr_hi && !locked && !sw_q)
            nsrc_d = wb_dat_i[ocl_pkg::NEXT_SRC_LSB +: 3];
        if (switch_done_i && sw_q)
            sw_d = 1'b0;
        if (clock_fail_detect_i)
            fail_d = 1'b1;
    end

    // status, mask and outputs; set wins over read-clear
    always_comb
    begin
        settled_d  = settled_raw;
        stat_d     = stat_q;
        mask_d     = mask_q;
        if (rd && wb_adr_i == ocl_pkg::IRQ_STAT_ADDR)
            stat_d = '0;
        if (wr && wb_adr_i == ocl_pkg::IRQ_MASK_ADDR && wb_sel_i[0])
            mask_d = wb_dat_i[2:0];
        if (clock_fail_detect_i)
            stat_d[ocl_pkg::IRQ_FAIL_BIT] = 1'b1;
        if (switch_done_i && sw_q)
            stat_d[ocl_pkg::IRQ_SWDONE_BIT] = 1'b1;
        if (settled_raw && !settled_q)
            stat_d[ocl_pkg::IRQ_SETTLE_BIT] = 1'b1;
        irq_d      = |(stat_d & mask_d);
        prim_run_d = prim_d || !sleep_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q      <= 1'b0;
            rdat_q     <= '0;
            unl_q      <= ocl_pkg::UNL_IDLE;
            freeze_q   <= ocl_pkg::FREEZE_RST;
            guard_q    <= ocl_pkg::GUARD_RST;
            settled_q  <= 1'b0;
            fail_q     <= 1'b0;
            prim_q     <= ocl_pkg::PRIM_RST;
            sec_q      <= ocl_pkg::SEC_RST;
            sw_q       <= 1'b0;
            // synchronous reset, so a strap may be sampled here
            nsrc_q     <= cfg_i.initial_osc_cfg;
            stat_q     <= '0;
            mask_q     <= ocl_pkg::IRQ_MASK_RST;
            irq_q      <= 1'b0;
            prim_run_q <= 1'b1;
        end
        else
        begin
            ack_q      <= ack_d;
            rdat_q     <= rdat_d;
            unl_q      <= unl_d;
            freeze_q   <= freeze_d;
            guard_q    <= guard_d;
            settled_q  <= settled_d;
            fail_q     <= fail_d;
            prim_q     <= prim_d;
            sec_q      <= sec_d;
            sw_q       <= sw_d;
            nsrc_q     <= nsrc_d;
            stat_q     <= stat_d;
            mask_q     <= mask_d;
            irq_q      <= irq_d;
            prim_run_q <= prim_run_d;
        end
    end

    assign wb_ack_o           = ack_q;
    assign wb_dat_o           = rdat_q;
    assign primary_osc_run_o  = prim_run_q;
    assign secondary_osc_on_o = sec_q;
    assign switch_start_o     = sw_q;
    assign next_source_o      = nsrc_q;
    // map register file refuses writes while this is high
    assign pin_map_locked_o   = guard_q;
    assign irq_o              = irq_q;

    a_freeze_blocks_switch: assert property (@(posedge clk_i) disable iff (rst_i)
        (locked && !sw_q) |=> !sw_q)
        else $error("switch started while selections frozen");
    a_unfrozen_switch_ok: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cfg_i.fail_monitor_cfg_bit && wr_lo && !key_write_chk && lo[0]) |=> sw_q)
        else $error("switch request lost with monitor off");
    a_guard_needs_key: assert property (@(posedge clk_i) disable iff (rst_i)
        (unl_q != ocl_pkg::UNL_ARMED) |=> $stable(guard_q))
        else $error("guard changed without unlock sequence");
    a_single_session: assert property (@(posedge clk_i) disable iff (rst_i)
        (cfg_i.single_session_map_cfg && guard_q) |=> guard_q)
        else $error("guard cleared in single session mode");
    a_settled_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (sw_q || !pll_i.pll_mode_selected) |=> !settled_q)
        else $error("pll flag high during switch or non pll mode");
    a_bit4_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q && (wb_adr_i == ocl_pkg::OSC_CTRL_ADDR) |-> !wb_dat_o[ocl_pkg::UNUSED_BIT])
        else $error("unimplemented bit read as one");
    a_fail_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        clock_fail_detect_i |=> fail_q ##1 (fail_q || $past(wr_lo)))
        else $error("clock fail flag lost");
    a_switch_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (sw_q && switch_done_i) |=> !sw_q ##1 (!sw_q || $past(wr_lo)))
        else $error("switch request not cleared on takeover");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        |(stat_q & mask_q) |-> irq_o)
        else $error("interrupt low with unmasked status");
    a_freeze_holds_src: assert property (@(posedge clk_i) disable iff (rst_i)
        (locked && wr_hi) |=> $stable(next_source_o))
        else $error("next source changed while selections frozen");
    a_guard_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        (unl_q == ocl_pkg::UNL_ARMED && wr_lo && lo[ocl_pkg::GUARD_BIT]) |=> guard_q)
        else $error("armed guard write did not set the guard");
    a_guard_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        (unl_q == ocl_pkg::UNL_ARMED && wr_lo && !lo[ocl_pkg::GUARD_BIT]
         && !cfg_i.single_session_map_cfg) |=> !guard_q)
        else $error("armed guard clear refused in multi session mode");
    a_settled_rises: assert property (@(posedge clk_i) disable iff (rst_i)
        (pll_i.pll_enabled && pll_i.pll_mode_selected && !sw_q && !switch_done_i
         && (pll_i.pll_locked || pll_i.pll_timer_done)) |=> settled_q)
        else $error("pll flag low although pll settled");
    a_settled_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !pll_i.pll_enabled |=> !settled_q)
        else $error("pll flag high with pll disabled");
    a_keep_in_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
        (prim_q && !wr_lo) |=> primary_osc_run_o)
        else $error("primary oscillator stopped although kept");
    a_stop_in_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
        (!prim_q && !wr_lo && sleep_i) |=> !primary_osc_run_o)
        else $error("primary oscillator running in sleep");
    a_sec_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lo && !key_write_chk) |=> secondary_osc_on_o == $past(lo[ocl_pkg::SEC_BIT]))
        else $error("secondary oscillator enable not written");
    // no disable: this one watches the reset edges themselves
    a_nsrc_from_cfg: assert property (@(posedge clk_i)
        rst_i |=> next_source_o == $past(cfg_i.initial_osc_cfg))
        else $error("next source not loaded from config at reset");
    a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|(stat_q & mask_q)) |-> !irq_o)
        else $error("interrupt high with no unmasked status");

    assign key_write_chk = wr_lo && unl_q != ocl_pkg::UNL_ARMED
                           && (lo == ocl_pkg::UNLOCK_KEY1 || lo == ocl_pkg::UNLOCK_KEY2);
endmodule

// >>> rtl/ocl_pkg.sv
package ocl_pkg;
    // register byte offsets
    localparam logic [7:0] OSC_CTRL_ADDR  = 8'h00;
    localparam logic [7:0] IRQ_STAT_ADDR  = 8'h04;
    localparam logic [7:0] IRQ_MASK_ADDR  = 8'h08;
    localparam logic [7:0] PLL_STAT_ADDR  = 8'h0C;

    // oscillator_control field positions
    localparam int FREEZE_BIT   = 7;
    localparam int GUARD_BIT    = 6;
    localparam int SETTLED_BIT  = 5;
    localparam int UNUSED_BIT   = 4;
    localparam int FAIL_BIT     = 3;
    localparam int PRIM_BIT     = 2;
    localparam int SEC_BIT      = 1;
    localparam int SWITCH_BIT   = 0;
    localparam int NEXT_SRC_LSB = 8;

    // unlock keys written to the low byte
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;

    // interrupt status bits
    localparam int IRQ_FAIL_BIT   = 0;
    localparam int IRQ_SWDONE_BIT = 1;
    localparam int IRQ_SETTLE_BIT = 2;
    localparam int IRQ_WIDTH      = 3;

    // reset values
    localparam logic [2:0] IRQ_MASK_RST  = 3'h0;
    localparam logic       FREEZE_RST    = 1'b0;
    localparam logic       GUARD_RST     = 1'b0;
    localparam logic       PRIM_RST      = 1'b0;
    localparam logic       SEC_RST       = 1'b0;

    typedef enum logic [1:0] {
        UNL_IDLE  = 2'b00,
        UNL_KEY1  = 2'b01,
        UNL_ARMED = 2'b11
    } ocl_unlock_type;

    typedef struct packed {
        logic       fail_monitor_cfg_bit;
        logic       single_session_map_cfg;
        logic [2:0] initial_osc_cfg;
    } ocl_cfg_type;

    typedef struct packed {
        logic pll_enabled;
        logic pll_locked;
        logic pll_timer_done;
        logic pll_mode_selected;
    } ocl_pll_type;
endpackage

// >>> sim/ocl_osc_ctrl_test.sv
`timescale 1ns/1ps
module ocl_osc_ctrl_test;
    logic                 clk_i;
    logic                 rst_i;
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [7:0]           adr;
    logic [3:0]           sel;
    logic [31:0]          wdat;
    logic [31:0]          rdat;
    logic [31:0]          rv;
    logic                 ack;
    ocl_pkg::ocl_cfg_type cfg;
    ocl_pkg::ocl_pll_type pll;
    logic                 fail_det;
    logic                 sw_done;
    logic                 sleep;
    logic                 prim_run;
    logic                 sec_on;
    logic                 sw_start;
    logic [2:0]           next_src;
    logic                 map_locked;
    logic                 irq;
    int                   miscompares;
    int                   checked;

    ocl_osc_ctrl i_ocl_osc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cfg_i(cfg), .pll_i(pll), .clock_fail_detect_i(fail_det),
        .switch_done_i(sw_done), .sleep_i(sleep), .primary_osc_run_o(prim_run),
        .secondary_osc_on_o(sec_on), .switch_start_o(sw_start), .next_source_o(next_src),
        .pin_map_locked_o(map_locked), .irq_o(irq));

    always #10 clk_i = ~clk_i;

    task automatic wrap_up();
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // master holds the request until the edge that samples ack high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            check(32'h0, 32'h1);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, s, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 4'hF, 32'h0, r);
        check(r, exp);
    endtask

    // key pair arms the guard for the next control write
    task automatic unlock();
        wr(8'h00, 4'h1, 32'h46);
        wr(8'h00, 4'h1, 32'h57);
    endtask

    // one-cycle strobe on the takeover input or on the fail detector
    task automatic pulse(input logic takeover);
        @(posedge clk_i);
        if (takeover)
            sw_done <= 1'b1;
        else
            fail_det <= 1'b1;
        @(posedge clk_i);
        sw_done  <= 1'b0;
        fail_det <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic reset_dut(input ocl_pkg::ocl_cfg_type c);
        cfg <= c;
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'h0;
        wdat = 32'h0; cfg = 5'h0D; pll = 4'h0; fail_det = 0; sw_done = 0; sleep = 0;
        miscompares = 0; checked = 0;
        reset_dut({1'b1, 1'b1, 3'h5});
        rd_chk(8'h00, 32'h0000_0500);
        check({31'h0, prim_run}, 32'h1);
        rd_chk(8'h10, 32'h0);
        wr(8'h00, 4'h1, 32'h16);
        rd_chk(8'h00, 32'h0000_0506);
        check({31'h0, sec_on}, 32'h1);
        sleep <= 1'b1;
        repeat (2) @(posedge clk_i);
        check({31'h0, prim_run}, 32'h1);
        wr(8'h00, 4'h1, 32'h02);
        repeat (2) @(posedge clk_i);
        check({31'h0, prim_run}, 32'h0);
        sleep <= 1'b0;
        // guard write without keys must not land; secondary stays on
        wr(8'h00, 4'h1, 32'h42);
        rd_chk(8'h00, 32'h0000_0502);
        unlock();
        wr(8'h00, 4'h1, 32'h42);
        rd_chk(8'h00, 32'h0000_0542);
        check({31'h0, map_locked}, 32'h1);
        unlock();
        wr(8'h00, 4'h1, 32'h02);
        rd_chk(8'h00, 32'h0000_0542);
        // clock fail: sticky, masked then unmasked interrupt
        wr(8'h08, 4'hF, 32'h0);
        pulse(1'b0);
        rd_chk(8'h00, 32'h0000_054A);
        check({31'h0, irq}, 32'h0);
        wr(8'h08, 4'hF, 32'h1);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq}, 32'h1);
        rd_chk(8'h04, 32'h1);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq}, 32'h0);
        rd_chk(8'h00, 32'h0000_054A);
        wr(8'h00, 4'h1, 32'h42);
        rd_chk(8'h00, 32'h0000_0542);
        // pll settles, then a switch to source 3
        pll <= 4'hF;
        repeat (2) @(posedge clk_i);
        rd_chk(8'h00, 32'h0000_0562);
        wr(8'h00, 4'h3, 32'h0343);
        check({28'h0, sw_start, next_src}, 32'hB);
        rd_chk(8'h00, 32'h0000_0343);
        pulse(1'b1);
        rd_chk(8'h00, 32'h0000_0362);
        pll <= 4'hE;
        repeat (2) @(posedge clk_i);
        rd_chk(8'h00, 32'h0000_0342);
        // settle rise and switch done both latched, then read-cleared
        rd_chk(8'h04, 32'h6);
        rd_chk(8'h04, 32'h0);
        // freeze blocks a switch only while the monitor is configured on
        wr(8'h00, 4'h1, 32'hC2);
        wr(8'h00, 4'h3, 32'h06C3);
        check({28'h0, sw_start, next_src}, 32'h3);
        rd_chk(8'h00, 32'h0000_03C2);
        cfg <= {1'b0, 1'b1, 3'h5};
        repeat (2) @(posedge clk_i);
        wr(8'h00, 4'h3, 32'h06C3);
        check({28'h0, sw_start, next_src}, 32'hE);
        pulse(1'b1);
        rd_chk(8'h00, 32'h0000_06C2);
        // multi-session map: guard can be cleared again
        reset_dut({1'b1, 1'b0, 3'h2});
        rd_chk(8'h00, 32'h0000_0200);
        check({31'h0, irq}, 32'h0);
        unlock();
        wr(8'h00, 4'h1, 32'h40);
        check({31'h0, map_locked}, 32'h1);
        unlock();
        wr(8'h00, 4'h1, 32'h00);
        check({31'h0, map_locked}, 32'h0);
        rd_chk(8'h00, 32'h0000_0200);
        wrap_up();
    end
endmodule
